// [hdl/rism_map.vh]
// Register offsets, field positions, reset values and timing of the reader interrupt block
`ifndef RISM_MAP_VH
`define RISM_MAP_VH

// ************************************************************
// Register offsets on the host register port
// ************************************************************
`define RISM_OFS_MAIN_MASK 6'h14
`define RISM_OFS_TIMER_MASK 6'h15
`define RISM_OFS_ERR_MASK 6'h16
`define RISM_OFS_MAIN_IRQ 6'h17
`define RISM_OFS_TIMER_IRQ 6'h18
`define RISM_OFS_ERR_IRQ 6'h19

// ************************************************************
// Reset values and read-clear patterns
// ************************************************************
`define RISM_RST_BYTE 8'h00
`define RISM_MAIN_MASK_USED 8'hfc
`define RISM_ALL_CLR 8'hff

// ************************************************************
// Summary register bit positions
// ************************************************************
`define RISM_MAIN_OSC 7
`define RISM_MAIN_WL 6
`define RISM_MAIN_RXS 5
`define RISM_MAIN_RXE 4
`define RISM_MAIN_TXE 3
`define RISM_MAIN_COL 2
`define RISM_MAIN_TIM 1
`define RISM_MAIN_ERR 0

// ************************************************************
// Timer and field event register bit positions
// ************************************************************
`define RISM_TIM_DCT 7
`define RISM_TIM_NRE 6
`define RISM_TIM_GPE 5
`define RISM_TIM_EON 4
`define RISM_TIM_EOF 3
`define RISM_TIM_CAC 2
`define RISM_TIM_CAT 1
`define RISM_TIM_NFCT 0

// ************************************************************
// Error and wake-up bit positions
// ************************************************************
`define RISM_ERR_CRC 7
`define RISM_ERR_PAR 6
`define RISM_ERR_SOFT 5
`define RISM_ERR_HARD 4
`define RISM_ERR_WT 3
`define RISM_ERR_WAM 2
`define RISM_ERR_WPH 1
`define RISM_ERR_WCAP 0

// ************************************************************
// Timing
// ************************************************************
`define RISM_CLK_MHZ 250
`define RISM_GUARD_TIME_NS 5000

`endif

// [hdl/rism_flag_bank.v]
// Bank of sticky event flags; a set beats a bit clear, clear-all beats a set
`timescale 1ns/1ps

module rism_flag_bank #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire sys_rst,
  input wire clr_all,
  input wire [WIDTH-1:0] clr_bits,
  input wire [WIDTH-1:0] set_bits,
  output reg [WIDTH-1:0] flags_q
);

  reg [WIDTH-1:0] flags_d;

  // A set in the clearing cycle survives, so no event is lost to a read
  always @*
  begin
    if (clr_all)
    begin
      flags_d = {WIDTH{1'b0}};
    end
    else
    begin
      flags_d = (flags_q & ~clr_bits) | set_bits;
    end
  end

  // Flag storage
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags_q <= {WIDTH{1'b0}};
    end
    else
    begin
      flags_q <= flags_d;
    end
  end

endmodule

// [hdl/rism_irq_ctrl.v]
// Interrupt flag, mask and read-clear logic of the reader front end
//
// Overview of operation
// - Error/wake-up mask bits 7..0 each silence one error or wake-up cause.
// - Error/wake-up mask resets to zero at power-up and set-default.
// - Summary bit 7 sets when the started oscillator becomes stable.
// - Summary bit 6 sets while receiving when the FIFO nears full.
// - Summary bit 6 also sets while sending when the FIFO nears empty.
// - Summary bits 5..2: receive start, receive end, send end, bit collision.
// - Summary bit 1 shows some timer/field flag is set.
// - Summary bit 0 shows some error/wake-up flag is set.
// - Summary and timer/field registers clear at power-up and set-default.
// - Reading the summary clears bits 7..2 and keeps bits 1 and 0.
// - Summary bits 1 and 0 clear only via reading their detail register or set-default.
// - Timer/field bits 7..5: command done, no-response and general timer expiry.
// - Timer/field bit 4 on external field rise, bit 3 on its drop.
// - Timer/field bit 2 when a field is sensed during collision avoidance.
// - Timer/field bit 1 after guard time once own field switched on.
// - Timer/field bit 0 when target mode recognises the initiator bit rate.
// - Timer/field register clears to zero when it is read.
// - Main mask bits 7..2 silence the matching summary causes.
// - Timer/field mask silences each timer/field flag at the same position.
// - Error/wake-up status bits 7..0 report causes in mask bit order.
`timescale 1ns/1ps
`include "rism_map.vh"

module rism_irq_ctrl #(
  parameter ADDR_W = 6,
  parameter GUARD_NS = `RISM_GUARD_TIME_NS
) (
  input wire clk,
  input wire sys_rst,
  // Host register port
  input wire [ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // Direct command restoring defaults
  input wire set_default_cmd,
  // Oscillator
  input wire osc_en,
  input wire osc_stable,
  // Transceiver and FIFO
  input wire rx_active,
  input wire tx_active,
  input wire fifo_near_full,
  input wire fifo_near_empty,
  input wire rx_start_evt,
  input wire rx_end_evt,
  input wire tx_end_evt,
  input wire bit_col_evt,
  // Timers and field detectors
  input wire cmd_done_evt,
  input wire nrt_expire_evt,
  input wire gpt_expire_evt,
  input wire ext_field_on,
  input wire ca_active,
  input wire ca_field_switched_evt,
  input wire bitrate_found_evt,
  // Error and wake-up causes, bit order as the status register
  input wire [7:0] err_wake_evt,
  // Interrupt request
  output reg irq_q
);

  // ************************************************************
  // Timing constants
  // ************************************************************
  // Least guard time, rounded up to whole cycles
  localparam integer GUARD_CYC_RAW = (GUARD_NS * `RISM_CLK_MHZ + 999) / 1000;
  localparam integer GUARD_CYC = (GUARD_CYC_RAW < 1) ? 1 : GUARD_CYC_RAW;
  localparam [15:0] GUARD_LAST = GUARD_CYC[15:0] - 16'h0001;

  // Guard state machine, one-hot
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_WAIT = 2'b10;

  // ************************************************************
  // Address decode
  // ************************************************************
  wire sel_main_mask = (reg_addr == `RISM_OFS_MAIN_MASK);
  wire sel_timer_mask = (reg_addr == `RISM_OFS_TIMER_MASK);
  wire sel_err_mask = (reg_addr == `RISM_OFS_ERR_MASK);
  wire sel_main_irq = (reg_addr == `RISM_OFS_MAIN_IRQ);
  wire sel_timer_irq = (reg_addr == `RISM_OFS_TIMER_IRQ);
  wire sel_err_irq = (reg_addr == `RISM_OFS_ERR_IRQ);

  // Read strobes that carry a clearing side effect
  wire rd_main_irq = reg_rd & sel_main_irq;
  wire rd_timer_irq = reg_rd & sel_timer_irq;
  wire rd_err_irq = reg_rd & sel_err_irq;

  // ************************************************************
  // Mask registers
  // ************************************************************
  reg [7:0] main_mask_q;
  reg [7:0] timer_mask_q;
  reg [7:0] error_wakeup_irq_mask_q;

  // Named views of the mask fields
  wire mask_soft_framing;
  wire mask_hard_framing;
  wire mask_wake_timer;

  assign mask_soft_framing = error_wakeup_irq_mask_q[`RISM_ERR_SOFT];
  assign mask_hard_framing = error_wakeup_irq_mask_q[`RISM_ERR_HARD];
  assign mask_wake_timer = error_wakeup_irq_mask_q[`RISM_ERR_WT];

  // Masks load on write; set-default restores all to unmasked
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      main_mask_q <= `RISM_RST_BYTE;
      timer_mask_q <= `RISM_RST_BYTE;
      error_wakeup_irq_mask_q <= `RISM_RST_BYTE;
    end
    else if (set_default_cmd)
    begin
      main_mask_q <= `RISM_RST_BYTE;
      timer_mask_q <= `RISM_RST_BYTE;
      error_wakeup_irq_mask_q <= `RISM_RST_BYTE;
    end
    else if (reg_wr)
    begin
      if (sel_main_mask)
      begin
        main_mask_q <= reg_wdata & `RISM_MAIN_MASK_USED;
      end
      if (sel_timer_mask)
      begin
        timer_mask_q <= reg_wdata;
      end
      if (sel_err_mask)
      begin
        error_wakeup_irq_mask_q <= reg_wdata;
      end
    end
  end

  // ************************************************************
  // Edge detection of level sources
  // ************************************************************
  reg osc_stable_q;
  reg water_cond_q;
  reg ext_field_q;
  reg ca_sense_q;
  wire water_cond;
  wire ca_sense;

  // Water level means near full on receive, near empty on send
  assign water_cond = (rx_active & fifo_near_full) | (tx_active & fifo_near_empty);
  assign ca_sense = ca_active & ext_field_on;

  // Previous values; inputs are synchronous so no synchroniser is needed
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      osc_stable_q <= 1'b0;
      water_cond_q <= 1'b0;
      ext_field_q <= 1'b0;
      ca_sense_q <= 1'b0;
    end
    else
    begin
      osc_stable_q <= osc_stable;
      water_cond_q <= water_cond;
      ext_field_q <= ext_field_on;
      ca_sense_q <= ca_sense;
    end
  end

  // Only a stable edge after software enabled the oscillator counts
  wire osc_rise = osc_en & osc_stable & ~osc_stable_q;
  wire water_rise = water_cond & ~water_cond_q;
  wire field_rise = ext_field_on & ~ext_field_q;
  wire field_fall = ~ext_field_on & ext_field_q;
  wire ca_col_rise = ca_sense & ~ca_sense_q;

  // ************************************************************
  // Guard timer after own field switch-on
  // ************************************************************
  reg [1:0] guard_st_q;
  reg [1:0] guard_st_d;
  reg [15:0] guard_cnt_q;
  reg [15:0] guard_cnt_d;
  reg guard_done;

  // A collision seen while waiting aborts the wait, the field lost the race
  always @*
  begin
    guard_st_d = guard_st_q;
    guard_cnt_d = guard_cnt_q;
    guard_done = 1'b0;
    case (guard_st_q)
      ST_IDLE:
      begin
        if (ca_field_switched_evt)
        begin
          guard_st_d = ST_WAIT;
          guard_cnt_d = 16'h0000;
        end
      end
      ST_WAIT:
      begin
        if (set_default_cmd | ca_col_rise)
        begin
          guard_st_d = ST_IDLE;
        end
        else if (guard_cnt_q == GUARD_LAST)
        begin
          guard_done = 1'b1;
          guard_st_d = ST_IDLE;
        end
        else
        begin
          guard_cnt_d = guard_cnt_q + 16'h0001;
        end
      end
      default:
      begin
        guard_st_d = ST_IDLE;
      end
    endcase
  end

  // Guard state and counter
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      guard_st_q <= ST_IDLE;
      guard_cnt_q <= 16'h0000;
    end
    else
    begin
      guard_st_q <= guard_st_d;
      guard_cnt_q <= guard_cnt_d;
    end
  end

  // ************************************************************
  // Event flag banks
  // ************************************************************
  wire [5:0] main_set;
  wire [7:0] timer_set;
  wire [5:0] main_flags;
  wire [7:0] timer_field_irq_status;
  wire [7:0] err_wake_status;

  // Summary causes in bit order 7..2
  assign main_set = {osc_rise, water_rise, rx_start_evt, rx_end_evt,
                     tx_end_evt, bit_col_evt};

  // Timer and field causes in bit order 7..0
  assign timer_set = {cmd_done_evt, nrt_expire_evt, gpt_expire_evt, field_rise,
                      field_fall, ca_col_rise, guard_done, bitrate_found_evt};

  // Summary bits 7..2 clear on a summary read
  rism_flag_bank #(
    .WIDTH(6)
  ) u_main_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr_all(set_default_cmd),
    .clr_bits({6{rd_main_irq}}),
    .set_bits(main_set),
    .flags_q(main_flags)
  );

  // Timer and field flags clear on their own read
  rism_flag_bank #(
    .WIDTH(8)
  ) u_timer_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr_all(set_default_cmd),
    .clr_bits({8{rd_timer_irq}}),
    .set_bits(timer_set),
    .flags_q(timer_field_irq_status)
  );

  // Error and wake-up flags clear on their own read
  rism_flag_bank #(
    .WIDTH(8)
  ) u_err_flags (
    .clk(clk),
    .sys_rst(sys_rst),
    .clr_all(set_default_cmd),
    .clr_bits({8{rd_err_irq}}),
    .set_bits(err_wake_evt),
    .flags_q(err_wake_status)
  );

  // ************************************************************
  // Summary view
  // ************************************************************
  wire [7:0] summary_irq_status;
  wire timer_any;
  wire err_any;

  // Bits 1 and 0 follow the detail registers, so only their reads or set-default clear them
  assign timer_any = |timer_field_irq_status;
  assign err_any = |err_wake_status;
  assign summary_irq_status = {main_flags, timer_any, err_any};

  // ************************************************************
  // Interrupt request
  // ************************************************************
  wire main_pend;
  wire timer_pend;
  wire err_pend;

  assign main_pend = |(main_flags & ~main_mask_q[7:2]);
  assign timer_pend = |(timer_field_irq_status & ~timer_mask_q);
  assign err_pend = |(err_wake_status & ~error_wakeup_irq_mask_q);

  // Registered so the pin never glitches; lags the flags by one cycle
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= main_pend | timer_pend | err_pend;
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  wire [7:0] rdata_d;

  // Unmapped offsets read as zero
  assign rdata_d = sel_main_mask ? main_mask_q :
                   sel_timer_mask ? timer_mask_q :
                   sel_err_mask ? error_wakeup_irq_mask_q :
                   sel_main_irq ? summary_irq_status :
                   sel_timer_irq ? timer_field_irq_status :
                   sel_err_irq ? err_wake_status : `RISM_RST_BYTE;

  // Captured on the same edge that clears, so the host sees the old flags
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      reg_rdata_q <= `RISM_RST_BYTE;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule

// [tb/rism_irq_asserts.sv]
// Port-level assertions for the reader interrupt block
`timescale 1ns/1ps

module rism_irq_asserts #(
  parameter ADDR_W = 6
) (
  input wire clk,
  input wire sys_rst,
  input wire [ADDR_W-1:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_q,
  input wire set_default_cmd,
  input wire irq_q
);
  reg clean_q;
  wire rd_sum = reg_rd && reg_addr == 6'h17;
  wire rd_hole = reg_rd && (reg_addr < 6'h14 || reg_addr > 6'h19);

  // Error mask untouched since reset or set-default, so it must read as zero
  always @(posedge clk or posedge sys_rst)
    if (sys_rst)
      clean_q <= 1'b1;
    else if (set_default_cmd || (reg_wr && reg_addr == 6'h16))
      clean_q <= set_default_cmd;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  hole_zero_a: assert property (rd_hole |=> reg_rdata_q == 8'h00)
    else $error("unmapped read not zero");
  mask_low_a: assert property (reg_rd && reg_addr == 6'h14 |=> reg_rdata_q[1:0] == 2'b00)
    else $error("main mask low bits not zero");
  err_mask_rst_a: assert property (reg_rd && reg_addr == 6'h16 && clean_q |=> reg_rdata_q == 8'h00)
    else $error("error mask not at default");
  err_mask_rw_a: assert property (reg_wr && reg_addr == 6'h16 ##2 reg_rd && reg_addr == 6'h16
    |=> reg_rdata_q == $past(reg_wdata, 3))
    else $error("error mask readback differs");
  keep_low_a: assert property (rd_sum ##2 rd_sum |=>
    (reg_rdata_q[1:0] & $past(reg_rdata_q[1:0], 2)) == $past(reg_rdata_q[1:0], 2))
    else $error("summary bits 1 or 0 lost by summary read");
  dflt_irq_a: assert property (set_default_cmd |-> ##2 !irq_q)
    else $error("request alive after set-default");
  irq_fall_a: assert property ($fell(irq_q) |-> $past(reg_rd || reg_wr || set_default_cmd, 2))
    else $error("request dropped with no host action");
endmodule

bind rism_irq_ctrl rism_irq_asserts #(.ADDR_W(ADDR_W)) u_chk (.clk, .sys_rst, .reg_addr,
  .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q, .set_default_cmd, .irq_q);

// [tb/rism_host_model.sv]
// Host controller model driving the register port of the interrupt block
`timescale 1ns/1ps

module rism_host_model (
  input wire clk,
  input wire [7:0] reg_rdata_q,
  output reg [5:0] reg_addr = 6'h3f,
  output reg reg_wr = 1'b0,
  output reg reg_rd = 1'b0,
  output reg [7:0] reg_wdata = 8'h00
);
  integer idle = 0; // Idle cycles before each access, models a slow host

  // Address and data are inverted on release so stale values never look valid
  task wr(input [5:0] a, input [7:0] d);
  begin
    repeat (idle) @(posedge clk);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  end
  endtask

  // Data is registered, so it is taken just after the edge that took the read
  task rd(input [5:0] a, output [7:0] d);
  begin
    repeat (idle) @(posedge clk);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata_q;
  end
  endtask

  // Summary first, then only the detail registers that it points at
  task service(output [7:0] s, output [7:0] t, output [7:0] e);
  begin
    t = 8'h00;
    e = 8'h00;
    rd(6'h17, s);
    if (s[1])
      rd(6'h18, t);
    if (s[0])
      rd(6'h19, e);
  end
  endtask
endmodule

// [tb/reader_irq_status_and_masking_test.sv]
// Self-checking bench for the reader interrupt flag and mask block
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin $display("FAIL %s exp %h got %h", n, e, a); n_errors++; end end

module reader_irq_status_and_masking_test;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg set_default_cmd = 1'b0;
  reg osc_en = 1'b1;
  reg osc_stable = 1'b0;
  reg rx_active = 1'b0, tx_active = 1'b0, fifo_near_full = 1'b0, fifo_near_empty = 1'b0;
  reg rx_start_evt = 1'b0, rx_end_evt = 1'b0, tx_end_evt = 1'b0, bit_col_evt = 1'b0;
  reg cmd_done_evt = 1'b0, nrt_expire_evt = 1'b0, gpt_expire_evt = 1'b0;
  reg ext_field_on = 1'b0, ca_active = 1'b0, ca_field_switched_evt = 1'b0;
  reg bitrate_found_evt = 1'b0;
  reg [7:0] err_wake_evt = 8'h00;
  wire [5:0] reg_addr;
  wire reg_wr, reg_rd, irq_q;
  wire [7:0] reg_wdata, reg_rdata_q;
  integer n_errors = 0, cmp_count = 0, i, p, b;
  reg [31:0] seed = 32'h7f5a;
  reg [7:0] s, t, e;
  reg [7:0] mk [0:2];

  always #2 clk = ~clk;

  // Guard time shortened to 10 cycles to keep the run brief
  rism_irq_ctrl #(.GUARD_NS(40)) DUT (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata_q, .set_default_cmd, .osc_en, .osc_stable, .rx_active, .tx_active,
    .fifo_near_full, .fifo_near_empty, .rx_start_evt, .rx_end_evt, .tx_end_evt, .bit_col_evt,
    .cmd_done_evt, .nrt_expire_evt, .gpt_expire_evt, .ext_field_on, .ca_active,
    .ca_field_switched_evt, .bitrate_found_evt, .err_wake_evt, .irq_q);
  rism_host_model host (.clk, .reg_rdata_q, .reg_addr, .reg_wr, .reg_rd, .reg_wdata);

  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // Field rise with collision avoidance running also flags the rise itself
  function [7:0] tim_exp(input integer k);
    tim_exp = (k == 2) ? 8'h14 : 8'h01 << k;
  endfunction

  task tick(input integer n);
  begin
    repeat (n) @(posedge clk);
    #1;
  end
  endtask

  task close_out;
  begin
    if (n_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask

  // Step 8 is the send-side water level; it must come first so the level rises
  task fire_sum(input integer j);
  begin
    @(posedge clk);
    osc_stable <= (j == 7);
    rx_active <= (j == 6);
    fifo_near_full <= (j == 6);
    tx_active <= (j == 8);
    fifo_near_empty <= (j == 8);
    rx_start_evt <= (j == 5);
    rx_end_evt <= (j == 4);
    tx_end_evt <= (j == 3);
    bit_col_evt <= (j == 2);
    @(posedge clk);
    {rx_start_evt, rx_end_evt, tx_end_evt, bit_col_evt} <= 4'h0;
  end
  endtask

  task fire_tim(input integer k);
  begin
    @(posedge clk);
    cmd_done_evt <= (k == 7);
    nrt_expire_evt <= (k == 6);
    gpt_expire_evt <= (k == 5);
    ext_field_on <= (k == 4 || k == 2);
    ca_active <= (k == 2);
    ca_field_switched_evt <= (k == 1);
    bitrate_found_evt <= (k == 0);
    @(posedge clk);
    {cmd_done_evt, nrt_expire_evt, gpt_expire_evt} <= 3'h0;
    {ca_field_switched_evt, bitrate_found_evt} <= 2'h0;
    if (k == 1)
    begin
      tick(5);
      host.rd(6'h18, t);
      `CHK("guard early", 8'h08, t)
      tick(12);
    end
  end
  endtask

  task check_clear;
  begin
    for (i = 8'h13; i <= 8'h1a; i = i + 1)
    begin
      host.rd(i[5:0], s);
      `CHK("cleared register", 8'h00, s)
    end
  end
  endtask

  // Stops a hung run
  initial
  begin
    #40000;
    n_errors = n_errors + 1;
    close_out;
  end

  initial
  begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    host.wr(6'h17, 8'hff);
    host.wr(6'h3f, 8'hff);
    check_clear;
    // Stability reached while the oscillator is not enabled raises no flag
    @(posedge clk);
    osc_en <= 1'b0;
    osc_stable <= 1'b1;
    tick(2);
    `CHK("osc disabled irq", 1'b0, irq_q)
    host.rd(6'h17, s);
    `CHK("osc disabled", 8'h00, s)
    @(posedge clk);
    osc_stable <= 1'b0;
    osc_en <= 1'b1;
    for (i = 0; i < 3; i = i + 1)
    begin
      seed = lfsr(seed);
      mk[i] = seed[7:0];
      host.wr(i[5:0] + 6'h14, mk[i]);
    end
    for (i = 2; i >= 0; i = i - 1)
    begin
      host.rd(i[5:0] + 6'h14, s);
      `CHK("mask readback", mk[i] & ((i == 0) ? 8'hfc : 8'hff), s)
    end
    // Pass 0 runs with random masks, pass 1 with the defaults
    for (p = 0; p < 2; p = p + 1)
    begin
      for (i = 8; i >= 2; i = i - 1)
      begin
        fire_sum(i);
        tick(2);
        b = (i == 8) ? 6 : i;
        `CHK("main irq", ~mk[0][b], irq_q)
        host.service(s, t, e);
        `CHK("main flags", 8'h01 << b, s)
        tick(2);
        `CHK("irq after read", 1'b0, irq_q)
      end
      for (i = 7; i >= 0; i = i - 1)
      begin
        fire_tim(i);
        tick(2);
        `CHK("timer irq", |(tim_exp(i) & ~mk[1]), irq_q)
        host.rd(6'h17, s);
        `CHK("summary bit1", 8'h02, s)
        host.service(s, t, e);
        `CHK("summary kept", 8'h02, s)
        `CHK("timer flags", tim_exp(i), t)
        tick(2);
        `CHK("irq after detail", 1'b0, irq_q)
      end
      host.idle = 3 * p;
      for (i = 7; i >= 0; i = i - 1)
      begin
        @(posedge clk);
        err_wake_evt <= 8'h01 << i;
        @(posedge clk);
        err_wake_evt <= 8'h00;
        tick(2);
        `CHK("error irq", ~mk[2][i], irq_q)
        host.service(s, t, e);
        `CHK("summary bit0", 8'h01, s)
        `CHK("error flags", 8'h01 << i, e)
        tick(2);
        `CHK("irq after error read", 1'b0, irq_q)
      end
      host.idle = 0;
      // An event on the edge of the clearing read must survive it
      fork
        host.rd(6'h17, s);
        fire_sum(3);
      join
      host.service(s, t, e);
      `CHK("set beats clear", 8'h08, s)
      fire_sum(3);
      @(posedge clk);
      set_default_cmd <= 1'b1;
      @(posedge clk);
      set_default_cmd <= 1'b0;
      tick(2);
      `CHK("irq after default", 1'b0, irq_q)
      check_clear;
      mk[0] = 8'h00;
      mk[1] = 8'h00;
      mk[2] = 8'h00;
    end
    close_out;
  end
endmodule
